// [core/sww_pkg.sv]
// Shared constants, register map and types of the sleep, wake and watchdog controller
package sww_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [13:0] IDX_TIMER  = 14'h0001;
  localparam logic [13:0] IDX_STATUS = 14'h0003;
  localparam logic [13:0] IDX_IRQCTL = 14'h000B;
  localparam logic [13:0] IDX_CMD    = 14'h0040;
  localparam logic [13:0] IDX_OPTION = 14'h0081;
  localparam logic [13:0] IDX_CONFIG = 14'h2007;

  // Interrupt control field positions
  localparam int GIE_BIT   = 7;
  localparam int TIMER_ZERO_OVERFLOW_ENABLE_BIT  = 5;
  localparam int EXTE_BIT  = 4;
  localparam int RBCE_BIT  = 3;
  localparam int TIMER_ZERO_OVERFLOW_FLAG_BIT  = 2;
  localparam int EXTF_BIT  = 1;
  localparam int RBCF_BIT  = 0;

  // Option control field positions
  localparam int EDGE_SEL_BIT = 6;
  localparam int PS_ASSIGN_BIT = 3;
  localparam int PS_RATIO_LSB  = 0;

  // Status, configuration and command field positions
  localparam int TO_BIT       = 4;
  localparam int PD_BIT       = 3;
  localparam int CFG_WATCHDOG_ENABLE_CFG_BIT = 2;
  localparam int CMD_KICK_BIT  = 0;
  localparam int CMD_SLEEP_BIT = 1;
  localparam int CMD_RETFIE_BIT = 2;

  // Reset values and vector
  localparam logic [7:0]  OPTION_RST = 8'hFF;
  localparam logic [7:0]  IRQCTL_RST = 8'h00;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  // Power state, Gray coded along run, sleep, wake
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE  = 2'b11
  } pwr_state_t;

endpackage : sww_pkg

// [core/sww_edge.sv]
// Edge detector for synchronous pin groups, silent until one sample is held
`timescale 1ns/10ps
module sww_edge #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rstn,
  // Sampled levels and detected edges
  input  wire logic [W-1:0] i_level,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);

  typedef struct packed {
    logic [W-1:0] prev;
    logic         armed;
  } edge_st_t;

  edge_st_t s_ff;
  edge_st_t nxt_s;

  initial begin
    if (W < 1) $error("sww_edge: W must be at least 1");
  end

  // Hold last sample and arm after the first one
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.prev  = i_level;
    nxt_s.armed = 1'b1;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Edges only once a previous sample exists
  assign o_rise = {W{s_ff.armed}} & i_level & ~s_ff.prev;
  assign o_fall = {W{s_ff.armed}} & ~i_level & s_ff.prev;

  a_edge_unarmed: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !s_ff.armed |-> (o_rise == '0 && o_fall == '0))
    else $error("edge reported before first sample");

endmodule // sww_edge

// [core/sww_wdog.sv]
// Watchdog base counter stepped by ticks of its own RC oscillator
`timescale 1ns/10ps
module sww_wdog #(
  parameter int PERIOD = 18
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  // Control
  input  wire logic i_osc_tick,
  input  wire logic i_enable,
  input  wire logic i_clear,
  // Base period done, one-cycle pulse
  output logic      o_base
);

  localparam int CW = $clog2(PERIOD);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          base;
  } wdog_st_t;

  wdog_st_t s_ff;
  wdog_st_t nxt_s;

  initial begin
    if (PERIOD < 2) $error("sww_wdog: PERIOD must be at least 2");
  end

  // Count oscillator ticks; off when not enabled by configuration
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.base = 1'b0;
    if (i_clear) begin
      nxt_s.cnt = '0;
    end else if (i_osc_tick && i_enable) begin
      if (s_ff.cnt == CW'(PERIOD - 1)) begin
        nxt_s.cnt  = '0;
        nxt_s.base = 1'b1;
      end else begin
        nxt_s.cnt = s_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_base = s_ff.base;

  a_wdog_disabled: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !i_enable |=> !o_base)
    else $error("watchdog stepped while disabled");

  a_wdog_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_clear |=> !o_base ##1 !o_base)
    else $error("watchdog expired right after clear");

endmodule // sww_wdog

// [core/sww_ctrl.sv]
// Sleep, wake, watchdog and core interrupt controller with Avalon-MM registers
`timescale 1ns/10ps
//
// Contract
// - External pin edge is rising when edge select is one, falling when zero.
// - Valid pin edge sets external flag bit 1, enable bit 4, sticky until cleared.
// - Pin interrupt wakes sleep only if enabled; global enable decides vectoring.
// - Timer zero rollover FF to 00 sets flag bit 2, enable bit 5.
// - Any change on upper four port pins sets flag bit 0, own enable.
// - Interrupt entry saves only the return address.
// - Watchdog counts on its own free-running oscillator, also during sleep.
// - Expiry while running resets the device; while asleep it wakes instead.
// - Every watchdog expiry clears the active-low timeout flag.
// - Watchdog is off whenever configuration enable bit 2 is zero.
// - One prescaler shared by timer and watchdog, assignment and ratio in option.
// - Kick and sleep clear watchdog and assigned prescaler, assignment unchanged.
// - Sleep clears watchdog, clears power-down flag, sets timeout, stops oscillator.
// - Pins hold their pre-sleep state while asleep.
// - Master clear in sleep resets; expiry or enabled interrupt continues.
// - Power-down flag set at power-up, cleared by each sleep.
// - In sleep only clock-free peripherals may raise wake requests.
// - Enabled interrupt wakes regardless of global enable; vector after prefetched op.
// - Sleep with enabled flag pending acts as no operation.
// - Interrupt during or after sleep lets sleep finish, then wakes at once.
// - Taking an interrupt clears global enable, pushes return, loads vector.
// - Flags set on events regardless of any enable.
module sww_ctrl
  import sww_pkg::*;
#(
  parameter int WDT_PERIOD = 18
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // Avalon-MM slave
  input  wire logic [15:0] i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Device pins and oscillator ticks
  input  wire logic        i_master_clear_pin_n,
  input  wire logic        i_ext_irq_pin,
  input  wire logic [3:0]  i_port_b_hi,
  input  wire logic        i_t0_tick,
  input  wire logic        i_wdt_osc_tick,
  input  wire logic [7:0]  i_config_word,
  input  wire logic        i_periph_wake,
  // Core side
  input  wire logic [12:0] i_pc_next,
  input  wire logic        i_instr_retire,
  output logic             o_vector_take,
  output logic      [12:0] o_vector_addr,
  output logic      [12:0] o_return_addr,
  // Reset and power outputs
  output logic             o_dev_reset,
  output logic             o_wdt_reset,
  output logic             o_osc_run,
  output logic             o_io_hold,
  output logic             o_sleeping
);

  typedef struct packed {
    pwr_state_t  st;
    logic [7:0]  irq;
    logic [7:0]  opt;
    logic        to_n;
    logic        pd_n;
    logic [7:0]  tmr;
    logic [7:0]  pre;
    logic        ack;
    logic [31:0] rdata;
    logic        vec;
    logic        wrst;
    logic [12:0] ret;
  } ctrl_st_t;

  ctrl_st_t s_ff;
  ctrl_st_t nxt_s;

  logic       ext_rise;
  logic       ext_fall;
  logic [3:0] rb_rise;
  logic [3:0] rb_fall;
  logic       wdt_base;
  logic       wdt_clr;

  initial begin
    if (WDT_PERIOD < 2) $error("sww_ctrl: WDT_PERIOD must be at least 2");
  end

  // Mask with the low n bits set
  function automatic logic [7:0] low_mask(input logic [3:0] n);
    logic [7:0] m;
    m = '0;
    for (int i = 0; i < 8; i++) begin
      m[i] = (4'(i) < n);
    end
    return m;
  endfunction

  // Register index match on a word-aligned byte address
  function automatic logic hit(input logic [15:0] a, input logic [13:0] idx);
    return (a[15:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  sww_edge #(.W(1)) u_ext_edge (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_level   (i_ext_irq_pin),
    .o_rise    (ext_rise),
    .o_fall    (ext_fall)
  );

  sww_edge #(.W(4)) u_rb_edge (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_level   (i_port_b_hi),
    .o_rise    (rb_rise),
    .o_fall    (rb_fall)
  );

  sww_wdog #(.PERIOD(WDT_PERIOD)) u_wdog (
    .i_ref_clk  (i_ref_clk),
    .i_rstn     (i_rstn),
    .i_osc_tick (i_wdt_osc_tick),
    .i_enable   (i_config_word[CFG_WATCHDOG_ENABLE_CFG_BIT]),
    .i_clear    (wdt_clr),
    .o_base     (wdt_base)
  );

  // Decoded events and commands
  logic       awake;
  logic       ext_ev;
  logic       rb_ev;
  logic       pending;
  logic       prescaler_assign;
  logic [3:0] ratio;
  logic       t0_step;
  logic       t0_inc;
  logic       pre_hit_t0;
  logic       pre_hit_wd;
  logic       wdt_exp;
  logic       bus_wr;
  logic       bus_rd;
  logic       cmd_kick;
  logic       cmd_sleep;
  logic       cmd_retfie;
  logic       sleep_go;

  always_comb begin
    awake      = (s_ff.st != ST_SLEEP);
    ext_ev     = s_ff.opt[EDGE_SEL_BIT] ? ext_rise : ext_fall;
    rb_ev      = |(rb_rise | rb_fall);
    pending    = |(s_ff.irq[TIMER_ZERO_OVERFLOW_ENABLE_BIT:RBCE_BIT] & s_ff.irq[TIMER_ZERO_OVERFLOW_FLAG_BIT:RBCF_BIT]);
    prescaler_assign        = s_ff.opt[PS_ASSIGN_BIT];
    ratio      = {1'b0, s_ff.opt[PS_RATIO_LSB +: 3]};
    t0_step    = i_t0_tick && awake;
    pre_hit_t0 = (s_ff.pre & low_mask(ratio + 4'd1)) == low_mask(ratio + 4'd1);
    pre_hit_wd = (s_ff.pre & low_mask(ratio)) == low_mask(ratio);
    t0_inc     = prescaler_assign ? t0_step : (t0_step && pre_hit_t0);
    wdt_exp    = wdt_base && (!prescaler_assign || pre_hit_wd);
    bus_wr     = i_avs_write && s_ff.ack;
    bus_rd     = i_avs_read && !s_ff.ack;
    cmd_kick   = bus_wr && hit(i_avs_address, IDX_CMD) && i_avs_writedata[CMD_KICK_BIT];
    cmd_sleep  = bus_wr && hit(i_avs_address, IDX_CMD) && i_avs_writedata[CMD_SLEEP_BIT];
    cmd_retfie = bus_wr && hit(i_avs_address, IDX_CMD) && i_avs_writedata[CMD_RETFIE_BIT];
    sleep_go   = cmd_sleep && !pending && (s_ff.st == ST_RUN);
    wdt_clr    = cmd_kick || sleep_go || !i_master_clear_pin_n;
  end

  // Next state of registers, flags and power sequencing
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.vec  = 1'b0;
    nxt_s.wrst = 1'b0;
    nxt_s.ack  = (i_avs_read || i_avs_write) && !s_ff.ack;

    // Read data captured on the first cycle, stands at the answering edge
    if (bus_rd) begin
      nxt_s.rdata = '0;
      if (hit(i_avs_address, IDX_IRQCTL)) nxt_s.rdata[7:0] = s_ff.irq;
      if (hit(i_avs_address, IDX_OPTION)) nxt_s.rdata[7:0] = s_ff.opt;
      if (hit(i_avs_address, IDX_TIMER))  nxt_s.rdata[7:0] = s_ff.tmr;
      if (hit(i_avs_address, IDX_CONFIG)) nxt_s.rdata[7:0] = i_config_word;
      if (hit(i_avs_address, IDX_STATUS)) begin
        nxt_s.rdata[TO_BIT] = s_ff.to_n;
        nxt_s.rdata[PD_BIT] = s_ff.pd_n;
      end
    end

    // Shared prescaler and timer zero
    if (!prescaler_assign && t0_step) begin
      nxt_s.pre = s_ff.pre + 8'h01;
    end else if (prescaler_assign && wdt_base) begin
      nxt_s.pre = s_ff.pre + 8'h01;
    end
    if (t0_inc) begin
      nxt_s.tmr = s_ff.tmr + 8'h01;
    end

    // Software writes
    if (bus_wr && hit(i_avs_address, IDX_IRQCTL)) nxt_s.irq = i_avs_writedata[7:0];
    if (bus_wr && hit(i_avs_address, IDX_OPTION)) nxt_s.opt = i_avs_writedata[7:0];
    if (bus_wr && hit(i_avs_address, IDX_TIMER))  nxt_s.tmr = i_avs_writedata[7:0];
    if (cmd_retfie) nxt_s.irq[GIE_BIT] = 1'b1;

    // Hardware flag sets win over a same-cycle software clear
    if (ext_ev) nxt_s.irq[EXTF_BIT] = 1'b1;
    if (rb_ev) nxt_s.irq[RBCF_BIT] = 1'b1;
    if (t0_inc && s_ff.tmr == 8'hFF) nxt_s.irq[TIMER_ZERO_OVERFLOW_FLAG_BIT] = 1'b1;

    // Watchdog kick; assignment bits untouched
    if (cmd_kick) begin
      nxt_s.to_n = 1'b1;
      nxt_s.pd_n = 1'b1;
      if (prescaler_assign) nxt_s.pre = '0;
    end

    // Power state machine
    unique case (s_ff.st)
      ST_RUN: begin
        if (sleep_go) begin
          nxt_s.st   = ST_SLEEP;
          nxt_s.pd_n = 1'b0;
          nxt_s.to_n = 1'b1;
          if (prescaler_assign) nxt_s.pre = '0;
        end else if (s_ff.irq[GIE_BIT] && pending && !cmd_sleep) begin
          nxt_s.vec          = 1'b1;
          nxt_s.irq[GIE_BIT] = 1'b0;
          nxt_s.ret          = i_pc_next;
        end
      end
      ST_SLEEP: begin
        if (wdt_exp) begin
          nxt_s.st = ST_RUN;
        end else if (pending || i_periph_wake) begin
          nxt_s.st = s_ff.irq[GIE_BIT] ? ST_WAKE : ST_RUN;
        end
      end
      ST_WAKE: begin
        if (i_instr_retire) begin
          nxt_s.st           = ST_RUN;
          nxt_s.vec          = 1'b1;
          nxt_s.irq[GIE_BIT] = 1'b0;
          nxt_s.ret          = i_pc_next;
        end
      end
      default: nxt_s.st = ST_RUN;
    endcase

    // Watchdog expiry: reset when running, wake when asleep
    if (wdt_exp) begin
      nxt_s.to_n = 1'b0;
      if (s_ff.st != ST_SLEEP) begin
        nxt_s.wrst = 1'b1;
        nxt_s.vec  = 1'b0;
        nxt_s.st   = ST_RUN;
        nxt_s.irq  = IRQCTL_RST;
        nxt_s.opt  = OPTION_RST;
        nxt_s.pre  = '0;
      end
    end

    // Master clear resets control state, also out of sleep
    if (!i_master_clear_pin_n) begin
      nxt_s.st  = ST_RUN;
      nxt_s.vec = 1'b0;
      nxt_s.irq = IRQCTL_RST;
      nxt_s.opt = OPTION_RST;
      nxt_s.pre = '0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_ff      <= '0;
      s_ff.st   <= ST_RUN;
      s_ff.opt  <= OPTION_RST;
      s_ff.irq  <= IRQCTL_RST;
      s_ff.to_n <= 1'b1;
      s_ff.pd_n <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs
  assign o_avs_readdata    = s_ff.rdata;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !s_ff.ack;
  assign o_vector_take     = s_ff.vec;
  assign o_vector_addr     = IRQ_VECTOR;
  assign o_return_addr     = s_ff.ret;
  assign o_wdt_reset       = s_ff.wrst;
  assign o_dev_reset       = s_ff.wrst || !i_master_clear_pin_n;
  assign o_sleeping        = (s_ff.st == ST_SLEEP);
  assign o_osc_run         = (s_ff.st != ST_SLEEP);
  assign o_io_hold         = (s_ff.st == ST_SLEEP);

  // Sleep entry sequences
  sequence sq_sleep_req;
    cmd_sleep && s_ff.st == ST_RUN && i_master_clear_pin_n && !wdt_exp;
  endsequence

  sequence sq_sleep_done;
    s_ff.st == ST_SLEEP && !s_ff.pd_n && s_ff.to_n && !o_osc_run;
  endsequence

  a_sleep_entry: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    sq_sleep_req and (!pending) |=> sq_sleep_done)
    else $error("sleep entry did not set flags and stop oscillator");

  a_sleep_nop: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    sq_sleep_req and pending |=> s_ff.st == ST_RUN && $stable(s_ff.pd_n))
    else $error("sleep with pending interrupt was not a no-op");

  a_wdt_run_rst: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    wdt_exp && s_ff.st == ST_RUN |=> o_wdt_reset && !s_ff.to_n && !s_ff.irq[GIE_BIT])
    else $error("watchdog expiry in run did not reset");

  a_wdt_sleep_wake: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    wdt_exp && o_sleeping && i_master_clear_pin_n |=> s_ff.st == ST_RUN && !s_ff.to_n && !o_wdt_reset)
    else $error("watchdog expiry in sleep did not wake");

  a_ext_flag_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ext_ev && i_master_clear_pin_n && !wdt_exp |=> s_ff.irq[EXTF_BIT])
    else $error("external edge did not set its flag");

  a_tmr_rollover: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    t0_inc && s_ff.tmr == 8'hFF && !bus_wr && i_master_clear_pin_n && !wdt_exp
    |=> s_ff.tmr == 8'h00 && s_ff.irq[TIMER_ZERO_OVERFLOW_FLAG_BIT])
    else $error("timer rollover did not set its flag");

  a_vector_take: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_vector_take |-> !s_ff.irq[GIE_BIT] && s_ff.st == ST_RUN)
    else $error("vector taken with global enable still set");

  a_wake_prefetch: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    s_ff.st == ST_WAKE && i_instr_retire && i_master_clear_pin_n && !wdt_exp
    |=> o_vector_take ##1 !o_vector_take)
    else $error("vector not taken after prefetched instruction");

  a_sleep_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_sleeping && !bus_wr |-> (o_io_hold && !t0_step) ##1 $stable(s_ff.tmr))
    else $error("pins or clocked timer active during sleep");

endmodule // sww_ctrl

// [sim/core_model.sv]
// Behavioural processor core that retires instructions and follows vectoring
`timescale 1ns/10ps
module core_model
  import sww_pkg::*;
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // Bench pacing and controller state
  input  wire logic        i_step,
  input  wire logic        i_sleeping,
  input  wire logic        i_vector_take,
  // Core side of the controller
  output logic      [12:0] o_pc_next,
  output logic             o_instr_retire
);
  // Retire one cycle after a bench step taken while the clock runs, even if sleep begins at that edge
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pc_next      <= 13'h0100;
      o_instr_retire <= 1'b0;
    end else begin
      o_instr_retire <= i_step & ~i_sleeping;
      if (i_vector_take) begin
        o_pc_next <= IRQ_VECTOR;
      end else if (o_instr_retire) begin
        o_pc_next <= o_pc_next + 13'h0001;
      end
    end
  end
endmodule // core_model

// [sim/tb.sv]
// Self-checking bench of the sleep, wake and watchdog controller
`timescale 1ns/10ps
module tb import sww_pkg::*; ;
  localparam logic [15:0] A_TMR = {IDX_TIMER, 2'b00};
  localparam logic [15:0] A_ST  = {IDX_STATUS, 2'b00};
  localparam logic [15:0] A_IRQ = {IDX_IRQCTL, 2'b00};
  localparam logic [15:0] A_CMD = {IDX_CMD, 2'b00};
  localparam logic [15:0] A_OPT = {IDX_OPTION, 2'b00};
  localparam logic [15:0] A_CFG = {IDX_CONFIG, 2'b00};
  localparam logic [15:0] A_BAD = 16'h0010;
  logic        i_ref_clk, i_rstn, i_avs_read, i_avs_write, i_master_clear_pin_n, i_ext_irq_pin;
  logic        i_t0_tick, i_wdt_osc_tick, i_periph_wake, retire, step;
  logic        o_avs_waitrequest, o_vector_take, o_dev_reset, o_wdt_reset;
  logic        o_osc_run, o_io_hold, o_sleeping;
  logic [15:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata;
  logic [3:0]  i_port_b_hi;
  logic [7:0]  i_config_word, q;
  logic [12:0] pc_next, o_vector_addr, o_return_addr;
  logic [2:0]  osc_div;
  int          error_cnt, checks, cyc, vt_cnt, wr_cnt;

  sww_ctrl #(.WDT_PERIOD(3)) DUT (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_master_clear_pin_n(i_master_clear_pin_n),
    .i_ext_irq_pin(i_ext_irq_pin), .i_port_b_hi(i_port_b_hi), .i_t0_tick(i_t0_tick),
    .i_wdt_osc_tick(i_wdt_osc_tick), .i_config_word(i_config_word),
    .i_periph_wake(i_periph_wake), .i_pc_next(pc_next), .i_instr_retire(retire),
    .o_vector_take(o_vector_take), .o_vector_addr(o_vector_addr),
    .o_return_addr(o_return_addr), .o_dev_reset(o_dev_reset), .o_wdt_reset(o_wdt_reset),
    .o_osc_run(o_osc_run), .o_io_hold(o_io_hold), .o_sleeping(o_sleeping));

  core_model core (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_step(step),
    .i_sleeping(o_sleeping), .i_vector_take(o_vector_take), .o_pc_next(pc_next),
    .o_instr_retire(retire));

  // Reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  // Free-running watchdog oscillator, event counters and hang limit
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    osc_div <= osc_div + 3'h1;
    i_wdt_osc_tick <= (osc_div == 3'h7);
    if (o_vector_take === 1'b1) vt_cnt <= vt_cnt + 1;
    if (o_wdt_reset === 1'b1) wr_cnt <= wr_cnt + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  // Avalon master: hold the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    i_avs_address <= a;
    i_avs_writedata <= {24'h000000, d};
    i_avs_write <= wr;
    i_avs_read <= ~wr;
    do begin
      @(posedge i_ref_clk);
    end while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata[7:0];
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_ref_clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [15:0] a, input logic [7:0] m,
                    input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(nm, exp, q & m);
  endtask

  // Reset values, read-only and unmapped places
  task automatic t_reset();
    rd("option", A_OPT, 8'hFF, OPTION_RST);
    rd("irqctl", A_IRQ, 8'hFF, IRQCTL_RST);
    rd("status", A_ST, 8'h18, 8'h18);
    wr(A_CFG, 8'hFF);
    rd("config", A_CFG, 8'hFF, 8'h00);
    wr(A_BAD, 8'h5A);
    rd("unmapped", A_BAD, 8'hFF, 8'h00);
  endtask

  // Both edge selections, with the wrong edge ignored
  task automatic t_edge();
    for (int e = 1; e >= 0; e--) begin
      wr(A_OPT, e[0] ? 8'hFF : 8'hBF);
      i_ext_irq_pin <= ~e[0];
      cyc_n(3);
      wr(A_IRQ, 8'h00);
      i_ext_irq_pin <= e[0];
      cyc_n(3);
      rd("ext flag", A_IRQ, 8'h02, 8'h02);
      wr(A_IRQ, 8'h00);
      i_ext_irq_pin <= ~e[0];
      cyc_n(3);
      rd("ext wrong edge", A_IRQ, 8'h02, 8'h00);
    end
  endtask

  // Each upper port pin alone raises the change flag
  task automatic t_port();
    for (int i = 0; i < 4; i++) begin
      wr(A_IRQ, 8'h00);
      i_port_b_hi[i] <= ~i_port_b_hi[i];
      cyc_n(3);
      rd("port flag", A_IRQ, 8'h01, 8'h01);
    end
  endtask

  // Timer rollover through the prescaler
  task automatic t_timer();
    wr(A_OPT, 8'hC0);
    wr(A_TMR, 8'hFF);
    wr(A_IRQ, 8'h20);
    repeat (4) begin
      i_t0_tick <= 1'b1;
      @(posedge i_ref_clk);
      i_t0_tick <= 1'b0;
      @(posedge i_ref_clk);
    end
    rd("t0 flag", A_IRQ, 8'h04, 8'h04);
  endtask

  // Sleep with an enabled flag already pending does nothing
  task automatic t_noop();
    wr(A_CMD, 8'h01);
    i_ext_irq_pin <= 1'b0;
    cyc_n(2);
    wr(A_IRQ, 8'h10);
    i_ext_irq_pin <= 1'b1;
    cyc_n(3);
    wr(A_CMD, 8'h02);
    @(negedge i_ref_clk);
    chk("noop sleeping", 1'b0, o_sleeping);
    @(posedge i_ref_clk);
    rd("noop status", A_ST, 8'h18, 8'h18);
  endtask

  // Sleep, wake by one source, then in-line or vectored resume
  task automatic t_sleep(input int src, input logic global_irq_enable);
    logic [12:0] p;
    int          vt0;
    vt0 = vt_cnt;
    wr(A_OPT, 8'hFF);
    i_ext_irq_pin <= 1'b0;
    step <= 1'b0;
    cyc_n(3);
    wr(A_IRQ, {global_irq_enable, 2'b00, src == 0, src == 1, 3'b000});
    wr(A_CMD, 8'h02);
    @(negedge i_ref_clk);
    chk("asleep", 1'b1, o_sleeping);
    chk("osc off", 1'b0, o_osc_run);
    chk("io hold", 1'b1, o_io_hold);
    @(posedge i_ref_clk);
    i_t0_tick <= 1'b1;
    rd("sleep status", A_ST, 8'h18, 8'h10);
    i_t0_tick <= 1'b0;
    case (src)
      0: i_ext_irq_pin <= 1'b1;
      1: i_port_b_hi[3] <= ~i_port_b_hi[3];
      default: i_periph_wake <= 1'b1;
    endcase
    cyc_n(3);
    i_periph_wake <= 1'b0;
    @(negedge i_ref_clk);
    chk("woken", 1'b0, o_sleeping);
    chk("osc on", 1'b1, o_osc_run);
    chk("vector early", vt0, vt_cnt);
    p = pc_next;
    @(posedge i_ref_clk);
    step <= 1'b1;
    @(posedge i_ref_clk);
    step <= 1'b0;
    cyc_n(3);
    chk("vector count", vt0 + int'(global_irq_enable), vt_cnt);
    if (global_irq_enable) begin
      chk("return addr", p, o_return_addr);
      chk("vector addr", IRQ_VECTOR, o_vector_addr);
      rd("global cleared", A_IRQ, 8'h80, 8'h00);
    end
    wr(A_IRQ, 8'h00);
  endtask

  // Kicks hold the watchdog off; expiry resets when running and wakes when asleep
  task automatic t_wdog();
    int w0;
    int n;
    i_config_word <= 8'h04;
    wr(A_OPT, 8'h49);
    w0 = wr_cnt;
    repeat (6) begin
      wr(A_CMD, 8'h01);
      cyc_n(20);
    end
    chk("kicked", w0, wr_cnt);
    wr(A_CMD, 8'h01);
    cyc_n(30);
    chk("early expiry", w0, wr_cnt);
    for (n = 0; n < 60 && wr_cnt == w0; n++) @(posedge i_ref_clk);
    chk("run expiry", w0 + 1, wr_cnt);
    cyc_n(2);
    rd("timeout flag", A_ST, 8'h10, 8'h00);
    rd("option reset", A_OPT, 8'hFF, 8'hFF);
    wr(A_OPT, 8'h49);
    wr(A_CMD, 8'h01);
    wr(A_CMD, 8'h02);
    for (n = 0; n < 90 && o_sleeping !== 1'b0; n++) @(posedge i_ref_clk);
    i_config_word <= 8'h00;
    chk("sleep expiry", w0 + 1, wr_cnt);
    rd("wake status", A_ST, 8'h18, 8'h00);
    wr(A_CMD, 8'h01);
    cyc_n(80);
    chk("disabled", w0 + 1, wr_cnt);
  endtask

  // Master clear while asleep resets the device
  task automatic t_master_clear_pin();
    wr(A_CMD, 8'h02);
    i_master_clear_pin_n <= 1'b0;
    cyc_n(2);
    @(negedge i_ref_clk);
    chk("master_clear_pin reset", 1'b1, o_dev_reset);
    chk("master_clear_pin wake", 1'b0, o_sleeping);
    @(posedge i_ref_clk);
    i_master_clear_pin_n <= 1'b1;
    cyc_n(2);
    rd("master_clear_pin option", A_OPT, 8'hFF, 8'hFF);
    wr(A_CMD, 8'h04);
    rd("global set", A_IRQ, 8'h80, 8'h80);
  endtask

  task automatic results();
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {i_rstn, i_avs_read, i_avs_write, i_ext_irq_pin, i_t0_tick} = 5'b00000;
    {i_wdt_osc_tick, i_periph_wake, step} = 3'b000;
    i_master_clear_pin_n = 1'b1;
    i_avs_address = 16'h0000;
    i_avs_writedata = 32'h00000000;
    i_port_b_hi = 4'h0;
    i_config_word = 8'h00;
    osc_div = 3'h0;
    {error_cnt, checks, cyc, vt_cnt, wr_cnt} = '0;
    cyc_n(20);
    i_rstn <= 1'b1;
    cyc_n(2);
    t_reset();
    t_edge();
    t_port();
    t_timer();
    t_noop();
    for (int s = 0; s < 3; s++) begin
      t_sleep(s, 1'b0);
      t_sleep(s, 1'b1);
    end
    t_wdog();
    t_master_clear_pin();
    results();
  end
endmodule // tb
